// ===== fls_consts.vh
// Shared constants for the flash erase, program and sleep command block.
`ifndef FLS_CONSTS_VH
`define FLS_CONSTS_VH

// Core clock rate in MHz; the cycle counts below are derived from it.
`define FLS_CLK_MHZ 125

// Self-timed operation times in microseconds.
`define FLS_BLOCK_ERASE_TIME_US 1000
`define FLS_ARRAY_ERASE_TIME_US 100000
`define FLS_PAGE_WRITE_TIME_US 1000
`define FLS_SLEEP_ENTRY_DELAY_US 10

// Cycle counts derived from the times above.
`define FLS_BLOCK_ERASE_CYC (`FLS_BLOCK_ERASE_TIME_US * `FLS_CLK_MHZ)
`define FLS_ARRAY_ERASE_CYC (`FLS_ARRAY_ERASE_TIME_US * `FLS_CLK_MHZ)
`define FLS_PAGE_WRITE_CYC (`FLS_PAGE_WRITE_TIME_US * `FLS_CLK_MHZ)
`define FLS_SLEEP_ENTRY_CYC (`FLS_SLEEP_ENTRY_DELAY_US * `FLS_CLK_MHZ)

// Command opcodes.
`define FLS_OP_WRITE_UNLOCK 8'h06
`define FLS_OP_FOUR_BYTE_ENTRY 8'hB7
`define FLS_OP_FOUR_BYTE_EXIT 8'hE9
`define FLS_OP_ERASE_64K 8'hD8
`define FLS_OP_CHIP_ERASE 8'h60
`define FLS_OP_PAGE_WRITE 8'h02
`define FLS_OP_QUAD_PAGE_WRITE 8'h38
`define FLS_OP_DEEP_SLEEP 8'hB9
`define FLS_OP_SLEEP_RELEASE 8'hAB

// Field positions: 64 KB block index starts at this address bit.
`define FLS_BLK_LSB 16
// Bytes in one program page.
`define FLS_PAGE_BYTES 256

`endif

// ===== fls_erase_prog.v
// Command sequencer for 64 KB erase, chip erase, page program and sleep.
`timescale 1ns/10ps
`default_nettype none
`include "fls_consts.vh"

// Operation
// - Block erase sets addressed 64KB block.
// - Block erase needs select rise after address.
// - Three address bytes, or four, or extension.
// - Opcode on one line or four lines.
// - Select rise starts timed op, flags.
// - Protected blocks are never erased.
// - Chip erase is opcode only, boundary checked.
// - Block-protect mode: chip erase needs level zero.
// - Sector mode: chip erase skips protected blocks.
// - Page program takes one to 256 bytes.
// - Over 256 bytes keeps the last 256.
// - Data wraps within the addressed page.
// - Program rejected unless select rises on byte.
// - Protected pages are never programmed.
// - Quad program needs quad enable and one-line mode; data on four lines.
// - Sleep accepted only after exactly eight bits.
// - After entry delay, only release is obeyed.
// - Release or reset leaves deep sleep.
// - Erase fail flag: set on fail, clear success.
// - Program fail flag: set on fail, clear success.
module fls_erase_prog #(
  parameter ADDR_W = 26,
  parameter [31:0] BLOCK_ERASE_CYC = `FLS_BLOCK_ERASE_CYC,
  parameter [31:0] ARRAY_ERASE_CYC = `FLS_ARRAY_ERASE_CYC,
  parameter [31:0] PAGE_WRITE_CYC = `FLS_PAGE_WRITE_CYC,
  parameter [31:0] SLEEP_ENTRY_CYC = `FLS_SLEEP_ENTRY_CYC
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Serial link pins from the host
  input wire cs_n,
  input wire sclk,
  input wire [3:0] quad_io_lines,
  // Configuration and protection settings, and the array result
  input wire quad_command_mode,
  input wire quad_enable_bit,
  input wire extended_addr_bit,
  input wire protect_scheme_select,
  input wire [3:0] block_protect_level,
  input wire sector_protect_bits,
  input wire array_fail,
  // Status
  output reg op_in_progress_flag_q,
  output reg write_unlock_latch_q,
  output reg erase_fail_flag_q,
  output reg prog_fail_flag_q,
  output reg four_byte_mode_q,
  output reg deep_sleep_q,
  // Array strobes
  output reg arr_erase_q,
  output reg arr_wr_q,
  output reg [ADDR_W-1:0] arr_addr_q,
  output reg [7:0] arr_data_q
);

  localparam BLK_W = ADDR_W - `FLS_BLK_LSB;

  // Link phases, one-hot.
  localparam [5:0] L_IDLE = 6'h01;
  localparam [5:0] L_OP = 6'h02;
  localparam [5:0] L_ADDR = 6'h04;
  localparam [5:0] L_NOARG = 6'h08;
  localparam [5:0] L_DATA = 6'h10;
  localparam [5:0] L_SKIP = 6'h20;

  // Operation states, one-hot.
  localparam [6:0] O_IDLE = 7'h01;
  localparam [6:0] O_CHECK = 7'h02;
  localparam [6:0] O_ERASE = 7'h04;
  localparam [6:0] O_PROG = 7'h08;
  localparam [6:0] O_WAIT = 7'h10;
  localparam [6:0] O_DPWAIT = 7'h20;
  localparam [6:0] O_SLEEP = 7'h40;

  // Block-protect level n guards the top 2^(n-1) blocks; zero guards none.
  function bp_prot;
    input [BLK_W-1:0] blk;
    input [3:0] lvl;
    begin
      if (lvl == 4'h0) begin
        bp_prot = 1'b0;
      end else begin
        bp_prot = ({{(32-BLK_W){1'b0}}, ~blk} < (32'h1 << (lvl - 4'h1)));
      end
    end
  endfunction

  // Pin synchronisers; only stage two and later feed logic.
  reg cs_s1, cs_s2, cs_s3;
  reg sck_s1, sck_s2, sck_s3;
  reg [3:0] sio_s1, sio_s2;

  // Link state.
  reg [5:0] lst_q; // Current framing phase.
  reg [7:0] sh_q; // Incoming shift register.
  reg [2:0] nbit_q; // Bits already held in the current byte.
  reg [7:0] cmd_q; // Latched opcode.
  reg [31:0] addr_q; // Collected address bytes.
  reg [1:0] abyte_q; // Address bytes received.
  reg [7:0] pcnt_q; // Data bytes received, modulo page size.
  reg data_seen_q; // At least one whole data byte arrived.
  reg [`FLS_PAGE_BYTES-1:0] pvalid_q; // Page slots holding new data.
  reg acc_q; // One-cycle pulse: command framed correctly.
  reg [7:0] pbuf [0:`FLS_PAGE_BYTES-1]; // Page staging buffer.

  // Operation state.
  reg [6:0] ost_q;
  reg [31:0] tmr_q; // Self-timed countdown.
  reg kind_erase_q; // The running operation is an erase.
  reg skip_q; // A protected block was skipped during chip erase.
  reg ph_q; // Chip erase walk: address phase versus decide phase.
  reg [BLK_W-1:0] blk_q; // Chip erase walk block index.
  reg [7:0] pidx_q; // Program walk slot index.

  // Link decode.
  wire cs_low = ~cs_s2;
  wire cs_rise = cs_s2 & ~cs_s3;
  wire cs_fall = ~cs_s2 & cs_s3;
  wire sck_rise = sck_s2 & ~sck_s3;
  wire is_quad_pp = (cmd_q == `FLS_OP_QUAD_PAGE_WRITE);
  // Quad mode moves everything on four lines; quad program only
  // widens after its opcode, which stays on one line.
  wire wide = quad_command_mode | (is_quad_pp & (lst_q != L_OP));
  wire [7:0] sh_d = wide ? {sh_q[3:0], sio_s2} : {sh_q[6:0], sio_s2[0]};
  wire [3:0] nsum = {1'b0, nbit_q} + (wide ? 4'h4 : 4'h1);
  wire byte_done = nsum[3];
  wire [1:0] alast = four_byte_mode_q ? 2'h3 : 2'h2;
  wire busy = (ost_q != O_IDLE);
  // Slot that the next data byte lands in; wrapping keeps the last page.
  wire [7:0] widx = addr_q[7:0] + pcnt_q;
  wire pb_wr = cs_low & sck_rise & byte_done & (lst_q == L_DATA) & ~busy;
  // Only a rise on a byte boundary, with nothing extra, frames a command.
  wire frame_ok = (nbit_q == 3'h0) & ((lst_q == L_NOARG) |
    ((lst_q == L_DATA) & data_seen_q));
  // Full target address: four bytes, or three plus the extension bit.
  wire [31:0] full_addr = four_byte_mode_q ? addr_q :
    {7'h00, extended_addr_bit, addr_q[23:0]};
  // Protection of the block that the array address points at.
  wire prot_hit = protect_scheme_select ? sector_protect_bits :
    bp_prot(arr_addr_q[ADDR_W-1:`FLS_BLK_LSB], block_protect_level);

  // Two-flop synchronisers plus a third stage for edge detection.
  always @(posedge mclk) begin
    if (rst) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      sio_s1 <= 4'h0;
      sio_s2 <= 4'h0;
    end else begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      sck_s1 <= sclk;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      sio_s1 <= quad_io_lines;
      sio_s2 <= sio_s1;
    end
  end

  // Page buffer write port; no reset, validity is tracked separately.
  // Writes are held off while busy so a running program reads stable data.
  always @(posedge mclk) begin
    if (pb_wr) begin
      pbuf[widx] <= sh_d;
    end
  end

  // Link framing: opcode, address, data, and the boundary check on rise.
  always @(posedge mclk) begin
    if (rst) begin
      lst_q <= L_IDLE;
      sh_q <= 8'h00;
      nbit_q <= 3'h0;
      cmd_q <= 8'h00;
      addr_q <= 32'h0;
      abyte_q <= 2'h0;
      pcnt_q <= 8'h00;
      data_seen_q <= 1'b0;
      pvalid_q <= {`FLS_PAGE_BYTES{1'b0}};
      acc_q <= 1'b0;
    end else begin
      acc_q <= 1'b0;
      if (cs_rise) begin
        // A rise anywhere but the expected boundary drops the command.
        acc_q <= frame_ok & (lst_q != L_IDLE);
        lst_q <= L_IDLE;
      end else if (cs_fall) begin
        lst_q <= L_OP;
        nbit_q <= 3'h0;
        addr_q <= 32'h0;
        abyte_q <= 2'h0;
        pcnt_q <= 8'h00;
        data_seen_q <= 1'b0;
      end else if (cs_low & sck_rise) begin
        sh_q <= sh_d;
        nbit_q <= nsum[2:0];
        case (lst_q)
          L_OP: begin
            if (byte_done) begin
              cmd_q <= sh_d;
              if ((sh_d == `FLS_OP_ERASE_64K) ||
                  (sh_d == `FLS_OP_PAGE_WRITE) ||
                  (sh_d == `FLS_OP_QUAD_PAGE_WRITE)) begin
                lst_q <= L_ADDR;
              end else begin
                lst_q <= L_NOARG;
              end
            end
          end
          L_ADDR: begin
            if (byte_done) begin
              addr_q <= {addr_q[23:0], sh_d};
              abyte_q <= abyte_q + 2'h1;
              if (abyte_q == alast) begin
                if (cmd_q == `FLS_OP_ERASE_64K) begin
                  lst_q <= L_NOARG;
                end else begin
                  lst_q <= L_DATA;
                  if (~busy) begin
                    pvalid_q <= {`FLS_PAGE_BYTES{1'b0}};
                  end
                end
              end
            end
          end
          L_DATA: begin
            if (byte_done) begin
              pcnt_q <= pcnt_q + 8'h01;
              data_seen_q <= 1'b1;
              if (~busy) begin
                pvalid_q[widx] <= 1'b1;
              end
            end
          end
          L_NOARG: begin
            // Any clock past the last expected bit spoils the frame.
            lst_q <= L_SKIP;
          end
          default: begin
            lst_q <= lst_q;
          end
        endcase
      end
    end
  end

  // Operation engine: accepts framed commands and runs timed work.
  always @(posedge mclk) begin
    if (rst) begin
      ost_q <= O_IDLE;
      tmr_q <= 32'h0;
      kind_erase_q <= 1'b0;
      skip_q <= 1'b0;
      ph_q <= 1'b0;
      blk_q <= {BLK_W{1'b0}};
      pidx_q <= 8'h00;
      write_unlock_latch_q <= 1'b0;
      erase_fail_flag_q <= 1'b0;
      prog_fail_flag_q <= 1'b0;
      four_byte_mode_q <= 1'b0;
      arr_erase_q <= 1'b0;
      arr_wr_q <= 1'b0;
      arr_addr_q <= {ADDR_W{1'b0}};
      arr_data_q <= 8'h00;
    end else begin
      arr_erase_q <= 1'b0;
      arr_wr_q <= 1'b0;
      case (ost_q)
        O_IDLE: begin
          // New commands are only taken here (release alone in O_SLEEP), never while busy.
          if (acc_q) begin
            case (cmd_q)
              `FLS_OP_WRITE_UNLOCK: begin
                write_unlock_latch_q <= 1'b1;
              end
              `FLS_OP_FOUR_BYTE_ENTRY: begin
                four_byte_mode_q <= 1'b1;
              end
              `FLS_OP_FOUR_BYTE_EXIT: begin
                four_byte_mode_q <= 1'b0;
              end
              `FLS_OP_DEEP_SLEEP: begin
                ost_q <= O_DPWAIT;
                tmr_q <= SLEEP_ENTRY_CYC;
              end
              `FLS_OP_ERASE_64K: begin
                if (write_unlock_latch_q) begin
                  kind_erase_q <= 1'b1;
                  arr_addr_q <= full_addr[ADDR_W-1:0];
                  ost_q <= O_CHECK;
                end
              end
              `FLS_OP_CHIP_ERASE: begin
                // Block-protect mode with any level set: ignored outright.
                if (write_unlock_latch_q & (protect_scheme_select |
                    (block_protect_level == 4'h0))) begin
                  kind_erase_q <= 1'b1;
                  skip_q <= 1'b0;
                  ph_q <= 1'b0;
                  blk_q <= {BLK_W{1'b0}};
                  ost_q <= O_ERASE;
                end
              end
              `FLS_OP_PAGE_WRITE, `FLS_OP_QUAD_PAGE_WRITE: begin
                // Quad program needs quad enable and the one-line mode.
                if (write_unlock_latch_q & (~is_quad_pp |
                    (quad_enable_bit & ~quad_command_mode))) begin
                  kind_erase_q <= 1'b0;
                  arr_addr_q <= full_addr[ADDR_W-1:0];
                  ost_q <= O_CHECK;
                end
              end
              default: begin
                ost_q <= O_IDLE;
              end
            endcase
          end
        end
        O_CHECK: begin
          // Protected target: record the failure and drop the latch.
          if (prot_hit) begin
            if (kind_erase_q) begin
              erase_fail_flag_q <= 1'b1;
            end else begin
              prog_fail_flag_q <= 1'b1;
            end
            write_unlock_latch_q <= 1'b0;
            ost_q <= O_IDLE;
          end else if (kind_erase_q) begin
            arr_erase_q <= 1'b1;
            skip_q <= 1'b0;
            tmr_q <= BLOCK_ERASE_CYC;
            ost_q <= O_WAIT;
          end else begin
            pidx_q <= 8'h00;
            ost_q <= O_PROG;
          end
        end
        O_ERASE: begin
          // Two cycles per block: present address, then read protection.
          if (~ph_q) begin
            arr_addr_q <= {blk_q, {`FLS_BLK_LSB{1'b0}}};
            ph_q <= 1'b1;
          end else begin
            ph_q <= 1'b0;
            if (prot_hit) begin
              skip_q <= 1'b1;
            end else begin
              arr_erase_q <= 1'b1;
            end
            blk_q <= blk_q + {{(BLK_W-1){1'b0}}, 1'b1};
            if (blk_q == {BLK_W{1'b1}}) begin
              tmr_q <= ARRAY_ERASE_CYC;
              ost_q <= O_WAIT;
            end
          end
        end
        O_PROG: begin
          // Walk every slot; only slots written this command are sent.
          arr_wr_q <= pvalid_q[pidx_q];
          arr_addr_q <= {arr_addr_q[ADDR_W-1:8], pidx_q};
          arr_data_q <= pbuf[pidx_q];
          pidx_q <= pidx_q + 8'h01;
          if (pidx_q == 8'hFF) begin
            tmr_q <= PAGE_WRITE_CYC;
            ost_q <= O_WAIT;
          end
        end
        O_WAIT: begin
          tmr_q <= tmr_q - 32'h1;
          if (tmr_q <= 32'h1) begin
            // Completion clears busy and the latch and reports the result.
            write_unlock_latch_q <= 1'b0;
            if (kind_erase_q) begin
              erase_fail_flag_q <= skip_q | array_fail;
            end else begin
              prog_fail_flag_q <= array_fail;
            end
            ost_q <= O_IDLE;
          end
        end
        O_DPWAIT: begin
          tmr_q <= tmr_q - 32'h1;
          if (tmr_q <= 32'h1) begin
            ost_q <= O_SLEEP;
          end
        end
        O_SLEEP: begin
          // Asleep: everything but the release command is ignored.
          if (acc_q & (cmd_q == `FLS_OP_SLEEP_RELEASE)) begin
            ost_q <= O_IDLE;
          end
        end
        default: begin
          ost_q <= O_IDLE;
        end
      endcase
    end
  end

  // Busy and deep-sleep outputs follow the engine state one cycle later.
  always @(posedge mclk) begin
    if (rst) begin
      op_in_progress_flag_q <= 1'b0;
      deep_sleep_q <= 1'b0;
    end else begin
      op_in_progress_flag_q <= (ost_q == O_CHECK) | (ost_q == O_ERASE) |
        (ost_q == O_PROG) | (ost_q == O_WAIT);
      deep_sleep_q <= (ost_q == O_SLEEP);
    end
  end

endmodule
`default_nettype wire

// ===== fls_erase_prog_properties.sv
// Concurrent checks on the erase, program and sleep sequencer ports.
`timescale 1ns/10ps
`default_nettype none
module fls_erase_prog_properties #(
  parameter ADDR_W = 26
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Link select and protection settings.
  input wire logic cs_n,
  input wire logic protect_scheme_select,
  input wire logic [3:0] block_protect_level,
  input wire logic sector_protect_bits,
  // Status and array strobes.
  input wire logic op_in_progress_flag_q,
  input wire logic write_unlock_latch_q,
  input wire logic deep_sleep_q,
  input wire logic arr_erase_q,
  input wire logic arr_wr_q,
  input wire logic [ADDR_W-1:0] arr_addr_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  localparam int NBLK = 1 << (ADDR_W - 16); // Blocks in the array.
  int blk_idx; // Block under the array address.
  int span; // Top blocks guarded by the protect level.
  assign blk_idx = int'(arr_addr_q[ADDR_W-1:16]);
  assign span = 1 << (block_protect_level - 4'h1);
  // A pulse is followed by the busy level, which lags the engine.
  sequence s_erase_then_busy;
    arr_erase_q ##1 op_in_progress_flag_q;
  endsequence
  a_erase_sets_busy: assert property (arr_erase_q |-> s_erase_then_busy)
    else $error("busy not raised after erase pulse");
  a_busy_end_latch: assert property ($fell(op_in_progress_flag_q) |-> !write_unlock_latch_q)
    else $error("latch still set when busy dropped");
  a_erase_needs_unlock: assert property (arr_erase_q |-> write_unlock_latch_q)
    else $error("erase pulse without unlock latch");
  a_write_needs_unlock: assert property (arr_wr_q |-> write_unlock_latch_q)
    else $error("write pulse without unlock latch");
  a_level_guard: assert property (arr_erase_q && !protect_scheme_select
    && block_protect_level != 4'h0 |-> blk_idx + span < NBLK)
    else $error("erase hit a level protected block");
  a_sector_guard: assert property (arr_erase_q && protect_scheme_select
    |-> !$past(sector_protect_bits))
    else $error("erase hit a sector protected block");
  a_page_wraps: assert property (arr_wr_q && $past(arr_wr_q)
    |-> (arr_addr_q >> 8) == ($past(arr_addr_q) >> 8))
    else $error("program left its page");
  a_sleep_quiet: assert property (deep_sleep_q |-> !arr_erase_q && !arr_wr_q)
    else $error("array touched in deep sleep");
  a_sleep_delay: assert property ($rose(deep_sleep_q) |-> cs_n && $past(cs_n, 16))
    else $error("deep sleep entered too early");
endmodule
`default_nettype wire

// ===== fls_host_model.sv
// Host controller model that clocks frames into the sequencer.
`timescale 1ns/10ps
`default_nettype none
module fls_host_model (
  // Link pins toward the device.
  output var logic cs_n,
  output var logic sclk,
  output var logic [3:0] sio
);
  logic [7:0] fb [0:299]; // Frame bytes, loaded before each send.
  // The link rests deselected with its clock still.
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sio = 4'hA;
  end
  // One clock pulse; data is set up half a period before the rise.
  task automatic pulse(input logic [3:0] v);
    begin
      sio = v;
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
  endtask
  // Bytes from qf on go as nibbles; ex spare bits break the boundary.
  task automatic send(input integer n, input integer qf, input integer ex);
    integer i;
    integer b;
    begin
      #3 cs_n = 1'b0;
      for (i = 0; i < n; i = i + 1) begin
        if (i >= qf) begin
          pulse(fb[i][7:4]);
          pulse(fb[i][3:0]);
        end else begin
          for (b = 7; b >= 0; b = b - 1) pulse({~sio[3:1], fb[i][b]});
        end
      end
      for (b = 0; b < ex; b = b + 1) pulse(~sio);
      #80 cs_n = 1'b1;
      // Released lines must not keep the last value.
      sio = ~sio;
      #400;
    end
  endtask
endmodule
`default_nettype wire

// ===== fls_erase_prog_bench.sv
// Self-checking bench for the erase, program and sleep sequencer.
`timescale 1ns/10ps
`default_nettype none
module fls_erase_prog_bench;
  logic mclk = 1'b0; // Core clock, 8 ns period.
  logic rst = 1'b1; // Synchronous reset.
  logic qmode = 1'b0, qen = 1'b0, ext = 1'b0, psel = 1'b0, afail = 1'b0;
  logic [3:0] bpl = 4'h0; // Block protect level.
  logic [3:0] spm = 4'h0; // Blocks holding a protected sector.
  wire logic cs_n, sclk, spb, busy, write_unlock_latch, efail, pfail, fbm, slp, aer, awr;
  wire logic [3:0] sio;
  wire logic [17:0] aad;
  wire logic [7:0] adt;
  integer mismatches = 0, tests_run = 0, cyc = 0, n_er = 0, n_wr = 0;
  integer q0 = 99; // First byte sent on four lines.
  integer k;
  logic [1:0] er_blk; // Block of the last erase pulse.
  logic [7:0] wr_mem [0:255]; // Bytes seen per page slot.
  always #4 mclk = ~mclk;
  // Sector protection answers for the block on the array address.
  assign spb = spm[aad[17:16]];
  fls_host_model host_u (.cs_n(cs_n), .sclk(sclk), .sio(sio));
  // Short timed waits keep the run small; block erase stays long for busy tests.
  fls_erase_prog #(.ADDR_W(18), .BLOCK_ERASE_CYC(32'h7D0),
    .ARRAY_ERASE_CYC(32'h14), .PAGE_WRITE_CYC(32'h14),
    .SLEEP_ENTRY_CYC(32'h14)) dut_u (.mclk(mclk), .rst(rst), .cs_n(cs_n),
    .sclk(sclk), .quad_io_lines(sio), .quad_command_mode(qmode),
    .quad_enable_bit(qen), .extended_addr_bit(ext),
    .protect_scheme_select(psel), .block_protect_level(bpl),
    .sector_protect_bits(spb), .array_fail(afail),
    .op_in_progress_flag_q(busy), .write_unlock_latch_q(write_unlock_latch),
    .erase_fail_flag_q(efail), .prog_fail_flag_q(pfail),
    .four_byte_mode_q(fbm), .deep_sleep_q(slp), .arr_erase_q(aer),
    .arr_wr_q(awr), .arr_addr_q(aad), .arr_data_q(adt));
  // Array strobe monitor and run limit.
  always @(posedge mclk) begin
    if (aer === 1'b1) begin
      n_er = n_er + 1;
      er_blk = aad[17:16];
    end
    if (awr === 1'b1) begin
      wr_mem[aad[7:0]] = adt;
      n_wr = n_wr + 1;
    end
    cyc = cyc + 1;
    if (cyc == 90000) begin
      mismatches = mismatches + 1;
      close_out;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
    end
  endtask
  task automatic close_out;
    begin
      $display("checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // One frame: opcode, three address bytes, n bytes in all.
  task automatic go(input logic [7:0] op, input logic [23:0] a,
    input integer n, input integer ex);
    begin
      n_er = 0;
      n_wr = 0;
      host_u.fb[0] = op;
      {host_u.fb[1], host_u.fb[2], host_u.fb[3]} = a;
      host_u.send(n, q0, ex);
    end
  endtask
  task automatic unl;
    go(8'h06, 24'h000000, 1, 0);
  endtask
  // Bounded wait for the timed operation to finish.
  task automatic idle;
    integer i;
    begin
      for (i = 0; i < 3000 && busy !== 1'b0; i = i + 1) @(posedge mclk);
      repeat (4) @(posedge mclk);
    end
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    check({busy, write_unlock_latch, efail, pfail, fbm, slp}, 32'h0);
    go(8'hD8, 24'h010000, 4, 0);
    idle;
    check(n_er, 32'h0);
    $display("test 1 finished");
    unl;
    check(write_unlock_latch, 32'h1);
    go(8'hD8, 24'h021234, 4, 1);
    idle;
    check(n_er, 32'h0);
    @(posedge mclk) afail <= 1'b1;
    go(8'hD8, 24'h02FFFF, 4, 0);
    go(8'hD8, 24'h000000, 4, 0);
    check(busy, 32'h1);
    idle;
    check({n_er, 2'b00, er_blk}, 32'h2);
    check({write_unlock_latch, efail}, 32'h1);
    $display("test 2 finished");
    @(posedge mclk) begin
      afail <= 1'b0;
      bpl <= 4'h1;
    end
    unl;
    go(8'hD8, 24'h030000, 4, 0);
    idle;
    check({n_er, write_unlock_latch}, 32'h0);
    unl;
    go(8'hD8, 24'h000000, 4, 0);
    idle;
    check({n_er, efail}, 32'h2);
    unl;
    go(8'h60, 24'h000000, 1, 0);
    idle;
    check({n_er, write_unlock_latch}, 32'h1);
    @(posedge mclk) begin
      bpl <= 4'h0;
      psel <= 1'b1;
      spm <= 4'h1;
    end
    go(8'h60, 24'h000000, 1, 2);
    idle;
    check(n_er, 32'h0);
    go(8'h60, 24'h000000, 1, 0);
    idle;
    check({n_er, efail}, 32'h7);
    $display("test 3 finished");
    unl;
    host_u.fb[4] = 8'h11;
    host_u.fb[5] = 8'h22;
    host_u.fb[6] = 8'h33;
    go(8'h02, 24'h0000F0, 5, 0);
    idle;
    check({n_wr, pfail}, 32'h1);
    unl;
    go(8'h02, 24'h010100, 5, 4);
    idle;
    check(n_wr, 32'h0);
    go(8'h02, 24'h0101FE, 7, 0);
    idle;
    check({n_wr, pfail}, 32'h6);
    check({wr_mem[8'hFE], wr_mem[8'hFF], wr_mem[8'h00]}, 32'h112233);
    $display("test 4 finished");
    unl;
    n_wr = 0;
    host_u.fb[0] = 8'h38;
    host_u.send(5, 1, 0);
    idle;
    check({n_wr, write_unlock_latch}, 32'h1);
    @(posedge mclk) qen <= 1'b1;
    {host_u.fb[1], host_u.fb[2], host_u.fb[3]} = 24'h010200;
    for (k = 0; k < 258; k = k + 1) host_u.fb[4 + k] = k[8:1];
    host_u.send(262, 1, 0);
    idle;
    check(n_wr, 32'h100);
    check({wr_mem[8'h00], wr_mem[8'h01], wr_mem[8'hFF]}, 32'h80807F);
    $display("test 5 finished");
    @(posedge mclk) qmode <= 1'b1;
    q0 = 0;
    unl;
    go(8'hD8, 24'h010000, 4, 0);
    idle;
    check({n_er, 2'b00, er_blk}, 32'h11);
    go(8'hB7, 24'h000000, 1, 0);
    check(fbm, 32'h1);
    unl;
    host_u.fb[4] = 8'h00;
    go(8'hD8, 24'h000300, 5, 0);
    idle;
    check({n_er, 2'b00, er_blk}, 32'h13);
    go(8'hE9, 24'h000000, 1, 0);
    check(fbm, 32'h0);
    @(posedge mclk) qmode <= 1'b0;
    q0 = 99;
    $display("test 6 finished");
    go(8'hB9, 24'h000000, 1, 1);
    check(slp, 32'h0);
    // Enter sleep with the latch set, so an obeyed chip erase would show.
    unl;
    go(8'hB9, 24'h000000, 1, 0);
    check(slp, 32'h1);
    go(8'h60, 24'h000000, 1, 0);
    check({n_er, write_unlock_latch}, 32'h1);
    go(8'hAB, 24'h000000, 1, 0);
    check(slp, 32'h0);
    $display("test 7 finished");
    close_out;
  end
endmodule
bind fls_erase_prog fls_erase_prog_properties #(.ADDR_W(ADDR_W)) prop_u (
  .mclk, .rst, .cs_n, .protect_scheme_select, .block_protect_level,
  .sector_protect_bits, .op_in_progress_flag_q, .write_unlock_latch_q,
  .deep_sleep_q, .arr_erase_q, .arr_wr_q, .arr_addr_q);
`default_nettype wire
